//--- core/ofc_cfg.sv
/*
 * oscillator power-up timeout and frequency offset compensation config
 * registers with the logic they steer, behind an ahb-lite slave.
 * assumes inputs synchronous to core_clk and one bus master.
 */
// The AHB-Lite interface to the registers was left to the implementer.
// Contract
// - timeout select gives 1/16/64/256 expiries
// - settled and ready change in the same cycle
// - no delay between settled and ready
// - keep-on bit holds oscillator on in sleep
// - gate bit freezes loops until carrier sense
// - pre-sync gain is one to four times base
// - post-sync gain: same as pre, or half base
// - saturation limit off, bw/8, bw/4, bw/2
// - ready low only after selected expiries
`timescale 1ns/1ps
`default_nettype none
module ofc_cfg #(
    parameter int OFS_W = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [ofc_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic osc_running,
    input wire logic expiry_tick,
    input wire logic in_sleep,
    input wire logic carrier_sense,
    input wire logic sync_found,
    input wire logic rx_start,
    input wire logic [OFS_W-1:0] channel_bandwidth,
    input wire logic signed [OFS_W:0] freq_offset_est,
    output logic osc_settled,
    output logic chip_ready_n,
    output logic osc_enable,
    output logic loops_frozen,
    output logic [3:0] freq_loop_gain,
    output logic signed [OFS_W:0] freq_offset_comp
);
    import ofc_pkg::*;

    logic [1:0] powerup_timeout_sel, next_powerup_timeout_sel;
    logic cfg0_spare, next_cfg0_spare;
    logic osc_keep_on_in_sleep, next_osc_keep_on_in_sleep;
    logic loop_freeze_until_carrier, next_loop_freeze_until_carrier;
    logic [1:0] freq_gain_before_sync, next_freq_gain_before_sync;
    logic freq_gain_after_sync, next_freq_gain_after_sync;
    logic [1:0] freq_offset_saturation, next_freq_offset_saturation;
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_idx, next_wr_idx;
    logic [31:0] next_hrdata;
    logic [7:0] a_idx;
    logic a_valid;

    // address decode; only word-sized transfers are used by the master
    always_comb
    begin
        a_idx = 8'(haddr >> ADDR_SHIFT);
        a_valid = hsel && hready &&
            (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    end

    // register file next values; unmapped reads give zero
    always_comb
    begin
        next_powerup_timeout_sel = powerup_timeout_sel;
        next_cfg0_spare = cfg0_spare;
        next_osc_keep_on_in_sleep = osc_keep_on_in_sleep;
        next_loop_freeze_until_carrier = loop_freeze_until_carrier;
        next_freq_gain_before_sync = freq_gain_before_sync;
        next_freq_gain_after_sync = freq_gain_after_sync;
        next_freq_offset_saturation = freq_offset_saturation;
        next_wr_pend = a_valid && hwrite;
        next_wr_idx = a_idx;
        next_hrdata = hrdata;
        if (wr_pend && wr_idx == IDX_STATE_CFG0)
        begin
            next_powerup_timeout_sel = hwdata[POS_PU_SEL +: 2];
            next_cfg0_spare = hwdata[POS_CFG0_SPARE];
            next_osc_keep_on_in_sleep = hwdata[POS_KEEP_ON];
        end
        if (wr_pend && wr_idx == IDX_FOC_CFG)
        begin
            // bits 7:6 have no storage, so writes there vanish
            next_loop_freeze_until_carrier = hwdata[POS_GATE];
            next_freq_gain_before_sync = hwdata[POS_PRE_K +: 2];
            next_freq_gain_after_sync = hwdata[POS_POST_K];
            next_freq_offset_saturation = hwdata[POS_LIMIT +: 2];
        end
        if (a_valid && !hwrite)
        begin
            next_hrdata = 32'h0;
            if (a_idx == IDX_STATE_CFG0)
            begin
                next_hrdata[POS_PU_SEL +: 2] = powerup_timeout_sel;
                next_hrdata[POS_CFG0_SPARE] = cfg0_spare;
                next_hrdata[POS_KEEP_ON] = osc_keep_on_in_sleep;
            end
            else if (a_idx == IDX_FOC_CFG)
            begin
                next_hrdata[POS_GATE] = loop_freeze_until_carrier;
                next_hrdata[POS_PRE_K +: 2] = freq_gain_before_sync;
                next_hrdata[POS_POST_K] = freq_gain_after_sync;
                next_hrdata[POS_LIMIT +: 2] = freq_offset_saturation;
            end
        end
    end

    // register file flops; zero wait state, always okay
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            powerup_timeout_sel <= RST_PU_SEL;
            cfg0_spare <= RST_CFG0_SPARE;
            osc_keep_on_in_sleep <= RST_KEEP_ON;
            loop_freeze_until_carrier <= RST_GATE;
            freq_gain_before_sync <= RST_PRE_K;
            freq_gain_after_sync <= RST_POST_K;
            freq_offset_saturation <= RST_LIMIT;
            wr_pend <= 1'b0;
            wr_idx <= 8'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            powerup_timeout_sel <= next_powerup_timeout_sel;
            cfg0_spare <= next_cfg0_spare;
            osc_keep_on_in_sleep <= next_osc_keep_on_in_sleep;
            loop_freeze_until_carrier <= next_loop_freeze_until_carrier;
            freq_gain_before_sync <= next_freq_gain_before_sync;
            freq_gain_after_sync <= next_freq_gain_after_sync;
            freq_offset_saturation <= next_freq_offset_saturation;
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ofc_pu_state_t pu_state, next_pu_state;
    logic [8:0] expiry_cnt, next_expiry_cnt;
    logic [8:0] expiry_target;
    logic next_osc_settled;

    // power-up timeout: count expiries once the crystal is running
    always_comb
    begin
        case (powerup_timeout_sel)
            2'h0: expiry_target = EXPIRE_SEL0;
            2'h1: expiry_target = EXPIRE_SEL1;
            2'h2: expiry_target = EXPIRE_SEL2;
            default: expiry_target = EXPIRE_SEL3;
        endcase
        next_pu_state = pu_state;
        next_expiry_cnt = expiry_cnt;
        case (pu_state)
            OFC_PU_WAIT:
            begin
                next_expiry_cnt = 9'h0;
                if (osc_running)
                    next_pu_state = OFC_PU_COUNT;
            end
            OFC_PU_COUNT:
            begin
                if (expiry_tick)
                    next_expiry_cnt = expiry_cnt + 9'h1;
                if (expiry_tick && expiry_cnt + 9'h1 >= expiry_target)
                    next_pu_state = OFC_PU_READY;
            end
            OFC_PU_READY:
                next_pu_state = OFC_PU_READY;
            default:
                next_pu_state = OFC_PU_WAIT;
        endcase
        // a stopped crystal restarts the whole timeout
        if (!osc_running)
            next_pu_state = OFC_PU_WAIT;
        next_osc_settled = (next_pu_state == OFC_PU_READY);
    end

    // both indications come from one decision, so no skew between them
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pu_state <= OFC_PU_WAIT;
            expiry_cnt <= 9'h0;
            osc_settled <= 1'b0;
            chip_ready_n <= 1'b1;
        end
        else
        begin
            pu_state <= next_pu_state;
            expiry_cnt <= next_expiry_cnt;
            osc_settled <= next_osc_settled;
            chip_ready_n <= !next_osc_settled;
        end
    end

    logic post_sync, next_post_sync;
    logic cs_seen, next_cs_seen;
    logic next_osc_enable;
    logic next_loops_frozen;
    logic [3:0] next_freq_loop_gain;
    logic [3:0] pre_gain;
    logic [OFS_W-1:0] limit_mag;
    logic signed [OFS_W:0] lim_pos, lim_neg, next_freq_offset_comp;

    // demodulator loop controls: gain, freeze and saturation
    always_comb
    begin
        next_post_sync = post_sync;
        next_cs_seen = cs_seen || carrier_sense;
        if (rx_start)
        begin
            next_post_sync = 1'b0;
            next_cs_seen = carrier_sense;
        end
        else if (sync_found)
            next_post_sync = 1'b1;
        next_osc_enable = !in_sleep || osc_keep_on_in_sleep;
        next_loops_frozen = loop_freeze_until_carrier && !next_cs_seen;
        pre_gain = 4'({freq_gain_before_sync, 1'b0}) + 4'h2;
        if (next_post_sync && freq_gain_after_sync)
            next_freq_loop_gain = GAIN_HALF;
        else
            next_freq_loop_gain = pre_gain;
        // ook users must program zero here; nothing checks it
        case (freq_offset_saturation)
            2'h1: limit_mag = channel_bandwidth >> 3;
            2'h2: limit_mag = channel_bandwidth >> 2;
            2'h3: limit_mag = channel_bandwidth >> 1;
            default: limit_mag = '0;
        endcase
        lim_pos = $signed({1'b0, limit_mag});
        lim_neg = -lim_pos;
        if (freq_offset_est > lim_pos)
            next_freq_offset_comp = lim_pos;
        else if (freq_offset_est < lim_neg)
            next_freq_offset_comp = lim_neg;
        else
            next_freq_offset_comp = freq_offset_est;
    end

    // loop control flops
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            post_sync <= 1'b0;
            cs_seen <= 1'b0;
            osc_enable <= 1'b1;
            loops_frozen <= RST_GATE;
            freq_loop_gain <= 4'({RST_PRE_K, 1'b0}) + 4'h2;
            freq_offset_comp <= '0;
        end
        else
        begin
            post_sync <= next_post_sync;
            cs_seen <= next_cs_seen;
            osc_enable <= next_osc_enable;
            loops_frozen <= next_loops_frozen;
            freq_loop_gain <= next_freq_loop_gain;
            freq_offset_comp <= next_freq_offset_comp;
        end
    end
endmodule : ofc_cfg
`default_nettype wire

//--- core/ofc_pkg.sv
/*
 * constants for the oscillator timeout and frequency offset configuration
 * block: register indices, field positions, reset values, encodings.
 * assumes a 32-bit ahb-lite bus with one register per aligned word.
 */
package ofc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATE_CFG0 = 8'h18;
    localparam logic [7:0] IDX_FOC_CFG = 8'h19;
    localparam int ADDR_SHIFT = 2;
    localparam int ADDR_W = 10;

    // state machine config fields
    localparam int POS_PU_SEL = 2;
    localparam int POS_CFG0_SPARE = 1;
    localparam int POS_KEEP_ON = 0;
    localparam logic [1:0] RST_PU_SEL = 2'h1;
    localparam logic RST_CFG0_SPARE = 1'b0;
    localparam logic RST_KEEP_ON = 1'b0;

    // frequency offset config fields
    localparam int POS_GATE = 5;
    localparam int POS_PRE_K = 3;
    localparam int POS_POST_K = 2;
    localparam int POS_LIMIT = 0;
    localparam logic RST_GATE = 1'b1;
    localparam logic [1:0] RST_PRE_K = 2'h2;
    localparam logic RST_POST_K = 1'b1;
    localparam logic [1:0] RST_LIMIT = 2'h2;

    // expiry counts per timeout setting
    localparam logic [8:0] EXPIRE_SEL0 = 9'h001;
    localparam logic [8:0] EXPIRE_SEL1 = 9'h010;
    localparam logic [8:0] EXPIRE_SEL2 = 9'h040;
    localparam logic [8:0] EXPIRE_SEL3 = 9'h100;

    // gain expressed in half-base-gain units
    localparam logic [3:0] GAIN_HALF = 4'h1;

    // ahb-lite transfer types
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef enum logic [2:0] {
        OFC_PU_WAIT = 3'b001,
        OFC_PU_COUNT = 3'b010,
        OFC_PU_READY = 3'b100
    } ofc_pu_state_t;
endpackage : ofc_pkg

//--- testbench/ofc_cfg_sva.sv
/* port-level properties of ofc_cfg.
   assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module ofc_cfg_chk #(
    parameter int OFS_W = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic osc_running,
    input wire logic expiry_tick,
    input wire logic in_sleep,
    input wire logic carrier_sense,
    input wire logic rx_start,
    input wire logic [OFS_W-1:0] channel_bandwidth,
    input wire logic signed [OFS_W:0] freq_offset_est,
    input wire logic [31:0] hrdata,
    input wire logic osc_settled,
    input wire logic chip_ready_n,
    input wire logic osc_enable,
    input wire logic loops_frozen,
    input wire logic [3:0] freq_loop_gain,
    input wire logic signed [OFS_W:0] freq_offset_comp
);
    logic signed [OFS_W:0] half_bw;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // widest limit is half the bandwidth, one edge behind the input
    always_ff @(posedge core_clk)
    begin
        half_bw <= {2'b0, channel_bandwidth[OFS_W-1:1]};
    end
    // carrier seen outside a reception restart
    sequence s_carrier;
        carrier_sense && !rx_start;
    endsequence
    property p_pair; chip_ready_n == !osc_settled; endproperty
    a_pair: assert property (p_pair) else $error("ready pair split");
    property p_tick; $rose(osc_settled) |-> $past(expiry_tick); endproperty
    a_tick: assert property (p_tick) else $error("settled w/o tick");
    property p_drop; $fell(osc_running) |=> !osc_settled; endproperty
    a_drop: assert property (p_drop) else $error("settled stuck");
    property p_awake; !in_sleep |=> osc_enable; endproperty
    a_awake: assert property (p_awake) else $error("osc off awake");
    property p_rel; s_carrier |=> !loops_frozen; endproperty
    a_rel: assert property (p_rel) else $error("loops still frozen");
    property p_rest; rx_start |=> freq_loop_gain inside {2, 4, 6, 8}; endproperty
    a_rest: assert property (p_rest) else $error("pre gain lost");
    property p_zero; freq_offset_est == 0 |=> freq_offset_comp == 0; endproperty
    a_zero: assert property (p_zero) else $error("comp not zero");
    property p_bound;
        freq_offset_comp <= half_bw && freq_offset_comp >= -half_bw;
    endproperty
    a_bound: assert property (p_bound) else $error("comp over limit");
    property p_hi; hrdata[31:8] == 0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
endmodule : ofc_cfg_chk
bind ofc_cfg ofc_cfg_chk #(.OFS_W(OFS_W)) u_chk (.core_clk, .rstn,
    .osc_running, .expiry_tick, .in_sleep, .carrier_sense, .rx_start,
    .channel_bandwidth, .freq_offset_est, .hrdata, .osc_settled,
    .chip_ready_n, .osc_enable, .loops_frozen, .freq_loop_gain,
    .freq_offset_comp);
`default_nettype wire

//--- testbench/ofc_cfg_tb.sv
/* directed bench for ofc_cfg over ahb-lite.
   assumes zero-wait slave and outputs one edge behind inputs. */
`timescale 1ns/1ps
`default_nettype none
module ofc_cfg_tb;
    import ofc_pkg::*;
    localparam logic [9:0] A0 = 10'(IDX_STATE_CFG0) << ADDR_SHIFT;
    localparam logic [9:0] A1 = 10'(IDX_FOC_CFG) << ADDR_SHIFT;
    logic core_clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
    logic osc_running, expiry_tick, in_sleep, carrier_sense;
    logic sync_found, rx_start, osc_settled, chip_ready_n;
    logic osc_enable, loops_frozen;
    logic [9:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [3:0] freq_loop_gain;
    logic [15:0] channel_bandwidth;
    logic signed [16:0] freq_offset_est, freq_offset_comp;
    int mismatches, checked;
    int cnt[4] = '{1, 16, 64, 256};
    assign hready = hreadyout;
    always #2.5 core_clk = ~core_clk;
    ofc_cfg DUT (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .osc_running, .expiry_tick, .in_sleep, .carrier_sense,
        .sync_found, .rx_start, .channel_bandwidth, .freq_offset_est,
        .osc_settled, .chip_ready_n, .osc_enable, .loops_frozen,
        .freq_loop_gain, .freq_offset_comp);
    task final_report;
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk
    // bounded wait for hready at a rising edge
    task rdy;
        int i;
        i = 0;
        do
        begin
            @(posedge core_clk);
            i++;
        end while (hready !== 1'b1 && i < 16);
        if (hready !== 1'b1)
        begin
            chk(32'(hready), 1);
            final_report;
        end
    endtask : rdy
    task bus(input int w, input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk);
        htrans <= HTRANS_NONSEQ;
        hwrite <= 1'(w);
        haddr <= a;
        rdy;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        rd = hrdata;
        chk(32'({hreadyout, hresp}), 32'h2);
    endtask : bus
    task wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wt
    task tick(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            expiry_tick <= 1'b1;
            @(posedge core_clk);
            expiry_tick <= 1'b0;
        end
        #1;
    endtask : tick
    // one-cycle sync match or reception start
    task strobe(input int sy);
        @(posedge core_clk);
        if (sy != 0) sync_found <= 1'b1;
        else rx_start <= 1'b1;
        @(posedge core_clk);
        sync_found <= 1'b0;
        rx_start <= 1'b0;
        wt(1);
    endtask : strobe
    initial
    begin
        {core_clk, rstn, hwrite, osc_running, expiry_tick} = '0;
        {in_sleep, carrier_sense, sync_found, rx_start} = '0;
        {haddr, htrans, hwdata, freq_offset_est} = '0;
        hsel = 1;
        hsize = 3'h2;
        channel_bandwidth = 16'h0800;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        bus(0, A0, 0);
        chk(rd, 32'h04);
        bus(0, A1, 0);
        chk(rd, 32'h36);
        bus(1, A1, '1);
        bus(0, A1, 0);
        chk(rd, 32'h3f);
        bus(1, 10'h068, '1);
        bus(0, 10'h068, 0);
        chk(rd, 0);
        // each timeout setting: not settled one tick early
        for (int s = 0; s < 4; s++)
        begin
            bus(1, A0, 32'(s) << 2);
            osc_running <= 1'b1;
            wt(2);
            tick(cnt[s] - 1);
            chk(32'(osc_settled), 0);
            tick(1);
            chk(32'({osc_settled, chip_ready_n}), 32'h2);
            @(posedge core_clk);
            osc_running <= 1'b0;
        end
        @(posedge core_clk);
        in_sleep <= 1'b1;
        wt(2);
        chk(32'(osc_enable), 0);
        bus(1, A0, 32'h05);
        // timeout select and keep-on bits must read back as written
        bus(0, A0, 0);
        chk(rd, 32'h05);
        wt(2);
        chk(32'(osc_enable), 1);
        strobe(0);
        chk(32'(loops_frozen), 1);
        @(posedge core_clk);
        carrier_sense <= 1'b1;
        in_sleep <= 1'b0;
        wt(2);
        chk(32'(loops_frozen), 0);
        @(posedge core_clk);
        carrier_sense <= 1'b0;
        // every pre gain with both post settings, gate off
        for (int k = 0; k < 8; k++)
        begin
            bus(1, A1, 32'(k << 2) | 32'h2);
            strobe(0);
            chk(32'(loops_frozen), 0);
            chk(32'(freq_loop_gain), 32'((k / 2 + 1) * 2));
            strobe(1);
            chk(32'(freq_loop_gain), (k % 2) ? 1 : 32'((k / 2 + 1) * 2));
            strobe(0);
            chk(32'(freq_loop_gain), 32'((k / 2 + 1) * 2));
        end
        // large offsets both ways clip at the selected limit
        for (int l = 0; l < 4; l++)
        begin
            bus(1, A1, 32'(l));
            freq_offset_est <= 17'sd4000;
            wt(2);
            chk(32'(freq_offset_comp), l ? 32'(2048 >> (4 - l)) : 0);
            @(posedge core_clk);
            freq_offset_est <= -17'sd4000;
            wt(2);
            chk(32'(freq_offset_comp), l ? -32'(2048 >> (4 - l)) : 0);
        end
        @(posedge core_clk);
        freq_offset_est <= 17'sd100;
        wt(2);
        chk(32'(freq_offset_comp), 32'd100);
        final_report;
    end
endmodule : ofc_cfg_tb
`default_nettype wire
